// ==== src/dcaa_top.sv ====
// four-channel dma arbiter, address-mode sequencer and register slave
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module dcaa_top
	import dcaa_pkg::*;
#(
	parameter logic [7:0] PSEL_MAP = PSEL_MAP_DEF // [R20]
) (
	input  wire logic        I_CLK,
	input  wire logic        I_RST,
	input  wire logic        I_CE,
	input  wire logic        I_AWVALID,
	output logic             O_AWREADY,
	input  wire logic [7:0]  I_AWADDR,
	input  wire logic        I_WVALID,
	output logic             O_WREADY,
	input  wire logic [31:0] I_WDATA,
	input  wire logic [3:0]  I_WSTRB,
	output logic             O_BVALID,
	input  wire logic        I_BREADY,
	output logic [1:0]       O_BRESP,
	input  wire logic        I_ARVALID,
	output logic             O_ARREADY,
	input  wire logic [7:0]  I_ARADDR,
	output logic             O_RVALID,
	input  wire logic        I_RREADY,
	output logic [31:0]      O_RDATA,
	output logic [1:0]       O_RRESP,
	input  wire logic [3:0]  I_EXT_REQ_N,
	input  wire logic        I_NMI,
	output logic [3:0]       O_ACK,
	output logic             O_BUS_CYC,
	output logic [31:0]      O_BUS_ADDR,
	output logic             O_BUS_WR,
	output logic [31:0]      O_BUS_WDATA,
	input  wire logic [31:0] I_BUS_RDATA
);
	logic [3:0]      rq_s1_r, rq_s2_r, rq_s3_r, edge_r;
	logic            nmi_s1_r, nmi_s2_r, nmi_s3_r;
	logic            me_r, nmi_abort_flag_r, aef_r;
	logic [1:0]      psel_r;
	logic [CT_W-1:0] ctl_r [4];
	logic [3:0]      te_r;
	logic [31:0]     src_r [4];
	logic [31:0]     dst_r [4];
	logic [31:0]     cnt_r [4];
	dcaa_state_t     st_r;
	logic [1:0]      ch_r, rr_r, pick, pmode, cam, cts, ack_left_r;
	logic [31:0]     ptr_r, a_addr_r, a_wdata_r, acc_rdata;
	logic            start_r, a_wr_r, a_long_r, acc_done;
	logic [3:0]      req, elig, cand;
	logic [7:0]      order;
	logic            pick_v, go, bad0, bad_ptr, err_set, unit_end;
	logic            awrdy_r, wrdy_r, wr_go;
	logic [7:0]      waddr_r;
	logic [31:0]     wdat_r, wm;
	logic [3:0]      wstrb_r;
	logic [1:0]      wch;
	logic            wr_op, wr_chan;

	function automatic logic misal(input logic [31:0] a, input logic [1:0] ts);
		misal = (ts == TS_WORD && a[0]) || (ts == TS_LONG && a[1:0] != 2'b00);
	endfunction

	function automatic logic ok_addr(input logic [7:0] a);
		ok_addr = a[1:0] == 2'b00 && (a == OFF_OP || a == OFF_STAT
			|| (a[7:4] >= CH_FIRST && a[7:4] <= CH_LAST));
	endfunction

	function automatic logic [1:0] chx(input logic [7:0] a);
		logic [3:0] t;
		t = a[7:4] - CH_FIRST;
		chx = t[1:0];
	endfunction

	function automatic logic [31:0] regval(input logic [7:0] a);
		logic [1:0] c;
		c = chx(a);
		regval = WORD_RST;
		if (a == OFF_OP) begin
			regval = {27'h0, aef_r, nmi_abort_flag_r, psel_r, me_r};
		end else if (a == OFF_STAT) begin
			regval = {24'h0, rr_r, ch_r, 1'b0, st_r};
		end else if (ok_addr(a)) begin
			case (a[3:0])
				OFF_SRC: regval = src_r[c];
				OFF_DST: regval = dst_r[c];
				OFF_CNT: regval = cnt_r[c];
				default: regval = {22'h0, ctl_r[c][CT_W-1:2], te_r[c],
					ctl_r[c][CT_EN]};
			endcase
		end
	endfunction

	// pins cross in through two flops; the second stage is read, and a third stage beside it for edge detection
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			rq_s1_r <= 4'hF;
			rq_s2_r <= 4'hF;
			rq_s3_r <= 4'hF;
			nmi_s1_r <= 1'b0;
			nmi_s2_r <= 1'b0;
			nmi_s3_r <= 1'b0;
		end else if (I_CE) begin
			rq_s1_r <= I_EXT_REQ_N;
			rq_s2_r <= rq_s1_r;
			rq_s3_r <= rq_s2_r;
			nmi_s1_r <= I_NMI;
			nmi_s2_r <= nmi_s1_r;
			nmi_s3_r <= nmi_s2_r;
		end
	end

	for (genvar g = 0; g < 4; g++) begin : g_ch
		logic [1:0] am;
		logic       sgl;
		assign am = ctl_r[g][CT_AM+:2];
		assign sgl = am == AM_SGL_RD || am == AM_SGL_WR; // [R7]
		assign req[g] = ctl_r[g][CT_EXT]
			? (ctl_r[g][CT_DS] ? edge_r[g] : ~rq_s2_r[g]) : 1'b1; // [R19]
		// acknowledge modes only on the external-request channels
		assign elig[g] = me_r & ctl_r[g][CT_EN] & ~te_r[g] & ~nmi_abort_flag_r
			& ~aef_r & (am == AM_DUAL || (am == AM_IND && g == 3)
			|| (sgl && ctl_r[g][CT_EXT] && g < 2)); // [R18] [R8] [R10]

		always_ff @(posedge I_CLK) begin
			if (I_RST) begin
				edge_r[g] <= 1'b0;
			end else if (I_CE) begin
				// a new edge in the clearing cycle is kept
				edge_r[g] <= (rq_s3_r[g] & ~rq_s2_r[g])
					| (edge_r[g] & ~(go & ~bad0 & pick == g)); // [R19]
			end
		end
	end

	assign cand = req & elig;
	assign pmode = PSEL_MAP[{psel_r, 1'b0} +: 2]; // [R20]

	always_comb begin
		case (pmode)
			2'h0: order = ORD_0123; // [R2]
			2'h1: order = ORD_0231;
			2'h2: order = ORD_2013;
			default: order = {rr_r + 2'd3, rr_r + 2'd2, rr_r + 2'd1, rr_r}; // [R5]
		endcase
		pick = 2'h0;
		pick_v = 1'b0;
		for (int k = 3; k >= 0; k--) begin
			if (cand[order[2*k +: 2]]) begin
				pick = order[2*k +: 2]; // [R1]
				pick_v = 1'b1;
			end
		end
	end

	assign go = st_r == S_IDLE && pick_v;
	assign cam = ctl_r[pick][CT_AM+:2];
	assign cts = ctl_r[pick][CT_TS+:2];
	assign bad0 = (cam == AM_IND ? misal(src_r[pick], TS_LONG)
		: misal(src_r[pick], cts) && cam != AM_SGL_WR)
		|| (misal(dst_r[pick], cts) && cam != AM_SGL_RD);
	assign bad_ptr = misal(ptr_r, ctl_r[ch_r][CT_TS+:2]);
	assign err_set = (go && bad0) || (st_r == S_NOP && bad_ptr);
	assign unit_end = I_CE && acc_done && (st_r == S_WR || st_r == S_SGL);

	// a unit in progress completes unless its fetched pointer is misaligned; later requests wait in idle
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			st_r <= S_IDLE;
			ch_r <= 2'h0;
			start_r <= 1'b0;
			a_addr_r <= WORD_RST;
			a_wdata_r <= WORD_RST;
			a_wr_r <= 1'b0;
			a_long_r <= 1'b0;
			ptr_r <= WORD_RST;
			ack_left_r <= 2'h0;
			O_ACK <= 4'h0;
		end else if (I_CE) begin
			start_r <= 1'b0;
			case (st_r)
				S_IDLE: if (go && !bad0) begin
					ch_r <= pick;
					start_r <= 1'b1;
					a_long_r <= cts == TS_LONG;
					a_addr_r <= cam == AM_SGL_WR ? dst_r[pick] : src_r[pick];
					a_wr_r <= cam == AM_SGL_WR;
					case (cam)
						AM_IND: begin
							a_long_r <= 1'b1; // [R14]
							st_r <= S_PTR; // [R13]
						end
						AM_SGL_RD, AM_SGL_WR: st_r <= S_SGL; // [R9]
						default: st_r <= S_RD; // [R11]
					endcase
				end
				S_PTR: if (acc_done) begin
					ptr_r <= acc_rdata; // [R13]
					st_r <= S_NOP; // [R15]
				end
				S_NOP: if (bad_ptr) begin
					st_r <= S_IDLE;
				end else begin
					a_addr_r <= ptr_r;
					a_long_r <= ctl_r[ch_r][CT_TS+:2] == TS_LONG;
					start_r <= 1'b1;
					st_r <= S_RD;
				end
				S_RD: if (acc_done) begin
					a_wdata_r <= acc_rdata; // [R12]
					a_addr_r <= dst_r[ch_r];
					a_wr_r <= 1'b1;
					start_r <= 1'b1;
					st_r <= S_WR;
				end
				S_WR: if (acc_done) begin
					st_r <= S_IDLE; // [R6]
				end
				S_SGL: begin
					// done comes a clock late, so the strobe counts its own clocks
					if (start_r) begin
						O_ACK[ch_r] <= 1'b1; // [R9]
						ack_left_r <= {a_long_r & ctl_r[ch_r][CT_NAR]
							& ctl_r[ch_r][CT_SLOW], (a_long_r
							& ctl_r[ch_r][CT_NAR]) | ctl_r[ch_r][CT_SLOW]}; // [R17]
					end else if (ack_left_r == 2'h0) begin
						O_ACK <= 4'h0; // [R9]
					end else begin
						ack_left_r <= ack_left_r - 2'h1;
					end
					if (acc_done) begin
						st_r <= S_IDLE;
					end
				end
				default: st_r <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			rr_r <= RR_RST; // [R4]
		end else if (unit_end) begin
			rr_r <= ch_r + 2'd1; // [R3] [R5]
		end
	end

	dcaa_access u_acc (
		.i_clk    (I_CLK),
		.i_rst    (I_RST),
		.i_ce     (I_CE),
		.i_start  (start_r),
		.i_addr   (a_addr_r),
		.i_wr     (a_wr_r),
		.i_wdata  (a_wdata_r),
		.i_long   (a_long_r),
		.i_narrow (ctl_r[ch_r][CT_NAR]),
		.i_slow   (ctl_r[ch_r][CT_SLOW]),
		.i_rdata  (I_BUS_RDATA),
		.o_cyc    (O_BUS_CYC),
		.o_addr   (O_BUS_ADDR),
		.o_wr     (O_BUS_WR),
		.o_wdata  (O_BUS_WDATA),
		.o_done   (acc_done),
		.o_rdata  (acc_rdata)
	);

	assign wr_go = ~awrdy_r & ~wrdy_r & ~O_BVALID;
	assign wr_op = wr_go && waddr_r == OFF_OP;
	assign wr_chan = wr_go && ok_addr(waddr_r) && waddr_r[7:4] >= CH_FIRST;
	assign wch = chx(waddr_r);
	always_comb begin
		wm = regval(waddr_r);
		for (int b = 0; b < 4; b++) begin
			if (wstrb_r[b]) begin
				wm[8*b +: 8] = wdat_r[8*b +: 8];
			end
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			awrdy_r <= 1'b1;
			wrdy_r <= 1'b1;
			O_BVALID <= 1'b0;
			O_BRESP <= RESP_OK;
			waddr_r <= OFF_OP;
			wdat_r <= WORD_RST;
			wstrb_r <= 4'h0;
			O_ARREADY <= 1'b1;
			O_RVALID <= 1'b0;
			O_RDATA <= WORD_RST;
			O_RRESP <= RESP_OK;
		end else if (I_CE) begin
			if (awrdy_r && I_AWVALID) begin
				awrdy_r <= 1'b0;
				waddr_r <= I_AWADDR;
			end
			if (wrdy_r && I_WVALID) begin
				wrdy_r <= 1'b0;
				wdat_r <= I_WDATA;
				wstrb_r <= I_WSTRB;
			end
			if (wr_go) begin
				O_BVALID <= 1'b1;
				O_BRESP <= ok_addr(waddr_r) ? RESP_OK : RESP_SLVERR;
			end
			if (O_BVALID && I_BREADY) begin
				O_BVALID <= 1'b0;
				awrdy_r <= 1'b1;
				wrdy_r <= 1'b1;
			end
			if (O_ARREADY && I_ARVALID) begin
				O_ARREADY <= 1'b0;
				O_RVALID <= 1'b1;
				O_RDATA <= regval(I_ARADDR);
				O_RRESP <= ok_addr(I_ARADDR) ? RESP_OK : RESP_SLVERR;
			end
			if (O_RVALID && I_RREADY) begin
				O_RVALID <= 1'b0;
				O_ARREADY <= 1'b1;
			end
		end
	end
	assign O_AWREADY = awrdy_r;
	assign O_WREADY = wrdy_r;

	// hardware set of a flag wins over a software clear in the same cycle
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			me_r <= 1'b0;
			psel_r <= 2'h0;
			nmi_abort_flag_r <= 1'b0;
			aef_r <= 1'b0;
			te_r <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				ctl_r[i] <= CTRL_RST;
				src_r[i] <= WORD_RST;
				dst_r[i] <= WORD_RST;
				cnt_r[i] <= WORD_RST;
			end
		end else if (I_CE) begin
			if (wr_op) begin
				me_r <= wm[OP_ME];
				psel_r <= wm[OP_PSEL +: 2];
			end
			nmi_abort_flag_r <= (nmi_s2_r & ~nmi_s3_r) | (nmi_abort_flag_r & ~(wr_op & ~wm[OP_NMI_ABORT_FLAG]));
			aef_r <= err_set | (aef_r & ~(wr_op & ~wm[OP_AEF]));
			for (int i = 0; i < 4; i++) begin
				if (wr_chan && wch == 2'(i)) begin
					case (waddr_r[3:0])
						OFF_SRC: src_r[i] <= wm;
						OFF_DST: dst_r[i] <= wm;
						OFF_CNT: cnt_r[i] <= wm;
						default: ctl_r[i] <= wm[CT_W-1:0];
					endcase
				end else if (unit_end && ch_r == 2'(i) && cnt_r[i] != WORD_RST) begin
					cnt_r[i] <= cnt_r[i] - 32'd1;
				end
				te_r[i] <= (unit_end && ch_r == 2'(i) && cnt_r[i] <= 32'd1)
					| (te_r[i] & ~(wr_chan && wch == 2'(i)
					&& waddr_r[3:0] == OFF_CTRL && !wm[CT_TE]));
			end
		end
	end

	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_RST || !I_CE);
	sequence s_ptr_done;
		st_r == S_PTR && acc_done;
	endsequence
	sequence s_nop_then_rd;
		st_r == S_NOP ##1 (st_r == S_RD || aef_r);
	endsequence
	sequence s_rd_done;
		st_r == S_RD && acc_done;
	endsequence
	a_nop_gap: assert property (s_ptr_done |=> s_nop_then_rd) // [R15]
		else $error("pointer read not followed by one idle cycle");
	a_dual_seq: assert property (s_rd_done |=> st_r == S_WR // [R12]
		##1 (O_BUS_CYC && O_BUS_WR && O_BUS_ADDR == dst_r[ch_r]))
		else $error("read not followed by destination write");
	a_rr_rotate: assert property (unit_end |=> rr_r == $past(ch_r) + 2'd1) // [R3]
		else $error("served channel not moved to lowest rank");
	a_rr_reset: assert property ($fell(I_RST) |-> rr_r == RR_RST) // [R4]
		else $error("round robin rank wrong after reset");
	a_fixed_top: assert property (go && pmode == 2'h2 && cand[2] // [R2]
		|-> pick == 2'h2)
		else $error("fixed order did not favour its top channel");
	a_grant_one: assert property (go && !bad0 && $countones(cand) > 1 // [R1]
		|=> ch_r == $past(pick) && st_r != S_IDLE)
		else $error("contending requests not resolved to one grant");
	a_eligible: assert property (go |-> me_r && !nmi_abort_flag_r && !aef_r // [R18]
		&& ctl_r[pick][CT_EN] && !te_r[pick])
		else $error("ineligible channel granted");
	a_hold_ch: assert property (st_r != S_IDLE |=> $stable(ch_r)) // [R6]
		else $error("channel changed inside a transfer unit");
	a_ack_cyc: assert property (O_ACK != 4'h0 |-> O_BUS_CYC // [R9]
		&& st_r == S_SGL)
		else $error("acknowledge outside a single address cycle");
	a_sgl_ext: assert property (st_r == S_SGL |-> ctl_r[ch_r][CT_EXT] // [R10]
		&& ch_r < 2'h2)
		else $error("single address transfer without external request");
	a_ind_ch3: assert property (st_r == S_PTR |-> ch_r == 2'h3 // [R13]
		&& a_long_r)
		else $error("indirect fetch off channel 3 or not 32-bit");
endmodule

// ==== src/dcaa_pkg.sv ====
// constants, types and behaviour summary for the dma arbiter and sequencer
// What this block does
// [R1] two or more requesting channels: one is granted by the selected scheme
// [R2] fixed orders: 0,1,2,3 or 0,2,3,1 or 2,0,1,3, highest first
// [R3] round robin: a channel finishing one unit drops to lowest priority
// [R4] after reset round robin ranks channel 0,1,2,3 highest first
// [R5] ranking rotates: after channel n, channel n+1 is highest
// [R6] late requests wait; arbitration reruns when the current unit ends
// [R7] single address (acknowledge strobe) and dual address transfers exist
// [R8] acknowledge device never pairs with on-chip space or another such device
// [R9] single address: one bus cycle, acknowledge with the memory address
// [R10] single address needs the external request and external memory side
// [R11] dual address: source and destination both reached by address
// [R12] direct dual: read into a holding register, write on next cycle
// [R13] indirect on channel 3: pointer fetch, data read, destination write
// [R14] the indirect pointer is always read as a full 32-bit value
// [R15] one idle cycle between pointer read and driving the pointer
// [R16] 32-bit unit on 16-bit port: each phase takes two bus cycles
// [R17] cycles per access follow the target space, one or two
// [R18] eligible only with both enables set and all three flags clear
// [R19] external request: low level when detect select is 0, falling edge if 1
// [R20] the priority field to scheme mapping is a parameter
package dcaa_pkg;
	localparam logic [7:0]  OFF_OP      = 8'h00;
	localparam logic [7:0]  OFF_STAT    = 8'h04;
	localparam logic [3:0]  CH_FIRST    = 4'h1;
	localparam logic [3:0]  CH_LAST     = 4'h4;
	localparam logic [3:0]  OFF_SRC     = 4'h0;
	localparam logic [3:0]  OFF_DST     = 4'h4;
	localparam logic [3:0]  OFF_CNT     = 4'h8;
	localparam logic [3:0]  OFF_CTRL    = 4'hC;
	localparam int          OP_ME       = 0;
	localparam int          OP_PSEL     = 1;
	localparam int          OP_NMI_ABORT_FLAG     = 3;
	localparam int          OP_AEF      = 4;
	localparam int          CT_EN       = 0;
	localparam int          CT_TE       = 1;
	localparam int          CT_DS       = 2;
	localparam int          CT_EXT      = 3;
	localparam int          CT_AM       = 4;
	localparam int          CT_TS       = 6;
	localparam int          CT_NAR      = 8;
	localparam int          CT_SLOW     = 9;
	localparam int          CT_W        = 10;
	localparam logic [9:0]  CTRL_RST    = 10'h000;
	localparam logic [31:0] WORD_RST    = 32'h0000_0000;
	localparam logic [31:0] HALF_STEP   = 32'h0000_0002;
	localparam logic [1:0]  AM_DUAL     = 2'h0;
	localparam logic [1:0]  AM_SGL_RD   = 2'h1;
	localparam logic [1:0]  AM_SGL_WR   = 2'h2;
	localparam logic [1:0]  AM_IND      = 2'h3;
	localparam logic [1:0]  TS_WORD     = 2'h1;
	localparam logic [1:0]  TS_LONG     = 2'h2;
	localparam logic [7:0]  ORD_0123    = 8'hE4;
	localparam logic [7:0]  ORD_0231    = 8'h78;
	localparam logic [7:0]  ORD_2013    = 8'hD2;
	localparam logic [7:0]  PSEL_MAP_DEF = 8'hE4;
	localparam logic [1:0]  RR_RST      = 2'h0;
	localparam logic [1:0]  RESP_OK     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_PTR  = 3'b001,
		S_NOP  = 3'b010,
		S_RD   = 3'b011,
		S_WR   = 3'b100,
		S_SGL  = 3'b101
	} dcaa_state_t;
endpackage

// ==== src/dcaa_access.sv ====
// one transfer access: one or two bus cycles, each one or two clocks
`timescale 1ns/1ps
module dcaa_access
	import dcaa_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_ce,
	input  wire logic        i_start,
	input  wire logic [31:0] i_addr,
	input  wire logic        i_wr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_long,
	input  wire logic        i_narrow,
	input  wire logic        i_slow,
	input  wire logic [31:0] i_rdata,
	output logic             o_cyc,
	output logic [31:0]      o_addr,
	output logic             o_wr,
	output logic [31:0]      o_wdata,
	output logic             o_done,
	output logic [31:0]      o_rdata
);
	logic        busy_r;
	logic        half_r;
	logic        wait_r;
	logic        two_r;
	logic        slow_r;
	logic [15:0] low_r;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			busy_r <= 1'b0;
			half_r <= 1'b0;
			wait_r <= 1'b0;
			two_r <= 1'b0;
			slow_r <= 1'b0;
			low_r <= 16'h0000;
			o_cyc <= 1'b0;
			o_addr <= WORD_RST;
			o_wr <= 1'b0;
			o_wdata <= WORD_RST;
			o_done <= 1'b0;
			o_rdata <= WORD_RST;
		end else if (i_ce) begin
			o_done <= 1'b0;
			if (i_start) begin
				busy_r <= 1'b1;
				o_cyc <= 1'b1;
				o_addr <= i_addr;
				o_wr <= i_wr;
				half_r <= 1'b0;
				wait_r <= i_slow; // [R17]
				slow_r <= i_slow;
				two_r <= i_long & i_narrow; // [R16]
				low_r <= i_wdata[15:0];
				// high half goes first on a split access
				o_wdata <= (i_long & i_narrow) ? {16'h0000, i_wdata[31:16]}
					: i_wdata;
			end else if (busy_r) begin
				if (wait_r) begin
					wait_r <= 1'b0;
				end else if (two_r && !half_r) begin
					o_rdata[31:16] <= i_rdata[15:0]; // [R16]
					half_r <= 1'b1;
					o_addr <= o_addr + HALF_STEP;
					o_wdata <= {16'h0000, low_r};
					wait_r <= slow_r; // [R17]
				end else begin
					if (two_r) begin
						o_rdata[15:0] <= i_rdata[15:0];
					end else begin
						o_rdata <= i_rdata;
					end
					busy_r <= 1'b0;
					o_cyc <= 1'b0;
					o_done <= 1'b1;
				end
			end
		end
	end
endmodule

// ==== verification/dcaa_mem_model.sv ====
// behavioural memory on the dma bus, answering within the same clock
`timescale 1ns/1ps
module dcaa_mem_model (
	input  wire logic        i_clk,
	input  wire logic        i_cyc,
	input  wire logic [31:0] i_addr,
	input  wire logic        i_wr,
	input  wire logic [31:0] i_wdata,
	output logic [31:0]      o_rdata
);
	logic [31:0] mem [0:255];
	logic [31:0] last_r;
	// outside a read the lines toggle, so a late sample never looks valid
	assign o_rdata = (i_cyc && !i_wr) ? mem[i_addr[7:0]] : ~last_r;
	always @(posedge i_clk) begin
		last_r <= o_rdata;
		if (i_cyc && i_wr)
			mem[i_addr[7:0]] <= i_wdata;
	end
	initial begin
		last_r = 32'h0;
		for (int i = 0; i < 256; i++)
			mem[i] = 32'h0;
	end
endmodule

// ==== verification/dcaa_top_bench.sv ====
// self-checking bench: register bus tasks and dma transfer scenarios
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
	err_total++; $display("ERROR %s exp %h got %h", nm, ex, got); end end
module dcaa_top_bench
	import dcaa_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        awvalid, wvalid, bready, arvalid, rready, nmi;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata;
	logic [3:0]  ext_req_n;
	wire         awready, wready, bvalid, arready, rvalid, bcyc, bwr;
	wire  [1:0]  bresp, rresp;
	wire  [3:0]  ack;
	wire  [31:0] rdata, baddr, bwdata, brdata;
	int          err_total = 0;
	int          n_tests = 0;
	int          hi_n = 0;
	int          h;
	logic [7:0]  a_q [$];
	logic        w_q [$];
	logic [3:0]  k_q [$];
	logic        cyc_d = 1'b0;
	logic [31:0] d;
	logic [1:0]  rs;
	logic [1:0]  ord [3][4] = '{'{0, 1, 2, 3}, '{0, 2, 3, 1}, '{2, 0, 1, 3}};

	always #5 clk = ~clk;

	dcaa_top #(.PSEL_MAP(PSEL_MAP_DEF)) dut (
		.I_CLK(clk), .I_RST(rst), .I_CE(1'b1),
		.I_AWVALID(awvalid), .O_AWREADY(awready), .I_AWADDR(awaddr),
		.I_WVALID(wvalid), .O_WREADY(wready), .I_WDATA(wdata),
		.I_WSTRB(4'hF), .O_BVALID(bvalid), .I_BREADY(bready),
		.O_BRESP(bresp), .I_ARVALID(arvalid), .O_ARREADY(arready),
		.I_ARADDR(araddr), .O_RVALID(rvalid), .I_RREADY(rready),
		.O_RDATA(rdata), .O_RRESP(rresp), .I_EXT_REQ_N(ext_req_n),
		.I_NMI(nmi), .O_ACK(ack), .O_BUS_CYC(bcyc), .O_BUS_ADDR(baddr),
		.O_BUS_WR(bwr), .O_BUS_WDATA(bwdata), .I_BUS_RDATA(brdata)
	);
	dcaa_mem_model mem (.i_clk(clk), .i_cyc(bcyc), .i_addr(baddr),
		.i_wr(bwr), .i_wdata(bwdata), .o_rdata(brdata));

	// one entry per bus access, taken in its first cycle
	always @(posedge clk) begin
		cyc_d <= bcyc;
		if (bcyc)
			hi_n <= hi_n + 1;
		if (bcyc && !cyc_d) begin
			a_q.push_back(baddr[7:0]);
			w_q.push_back(bwr);
			k_q.push_back(ack);
		end
	end

	task final_report;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task hang(input string what);
		err_total++;
		$display("ERROR %s exp done got timeout", what);
		final_report;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
		int k;
		@(posedge clk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= v;
		bready <= 1'b1;
		for (k = 0; k < 100; k++) begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid)
				break;
		end
		if (k == 100)
			hang("write");
		r = bresp;
		bready <= 1'b0;
	endtask

	task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		int k;
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		for (k = 0; k < 100; k++) begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		if (k == 100)
			hang("read");
		v = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task cw(input logic [7:0] a, input logic [31:0] v);
		logic [1:0] r;
		wr(a, v, r);
		`CHK("bresp", RESP_OK, r)
	endtask

	task setup(input int n, input logic [7:0] s, input logic [7:0] t,
			input logic [31:0] cnt, input logic [31:0] ctl);
		logic [7:0] b;
		b = 8'h10 + 8'(16 * n);
		cw(b + OFF_SRC, {24'h0, s});
		cw(b + OFF_DST, {24'h0, t});
		cw(b + OFF_CNT, cnt);
		cw(b + OFF_CTRL, ctl);
	endtask

	// starts the channels and expects exactly n bus accesses
	task go(input logic [31:0] op, input int n);
		int k;
		a_q.delete();
		w_q.delete();
		k_q.delete();
		cw(OFF_OP, op);
		for (k = 0; k < 2000 && a_q.size() < n; k++)
			@(posedge clk);
		if (k == 2000)
			hang("transfer");
		repeat (20) @(posedge clk);
		`CHK("access count", n, a_q.size())
		cw(OFF_OP, 32'h0);
	endtask

	function automatic logic [31:0] ctl(logic [1:0] am, logic ext, logic ds);
		logic [31:0] v;
		v = 32'h1;
		v[CT_EXT] = ext;
		v[CT_DS] = ds;
		v[CT_AM+:2] = am;
		v[CT_TS+:2] = TS_LONG;
		return v;
	endfunction

	initial begin
		{awvalid, wvalid, bready, arvalid, rready, nmi} = 6'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		ext_req_n = 4'hF;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd(OFF_OP, d, rs);
		`CHK("operation reg", 32'h0, d)
		rd(8'h1C, d, rs);
		`CHK("ch0 control", 32'h0, d)
		rd(8'hF0, d, rs);
		`CHK("unmapped rresp", RESP_SLVERR, rs)
		`CHK("unmapped rdata", 32'h0, d)
		wr(8'hF0, 32'hFFFF_FFFF, rs);
		`CHK("unmapped bresp", RESP_SLVERR, rs)
		for (int n = 0; n < 4; n++)
			mem.mem[8'h40 + 4 * n] = 32'hC0DE_0000 + n;
		// direct dual on ch0, one unit: read source then write destination
		setup(0, 8'h40, 8'h80, 32'h1, ctl(AM_DUAL, 1'b0, 1'b0));
		go(32'h1, 2);
		`CHK("direct rd addr", 8'h40, a_q[0])
		`CHK("direct wr addr", 8'h80, a_q[1])
		`CHK("direct kinds", 2'b01, {w_q[0], w_q[1]})
		`CHK("direct data", 32'hC0DE_0000, mem.mem[8'h80])
		// indirect on ch3: pointer, data read at pointer, write destination
		mem.mem[8'h10] = 32'h0000_0060;
		mem.mem[8'h60] = 32'h5A5A_1234;
		setup(3, 8'h10, 8'h90, 32'h1, ctl(AM_IND, 1'b0, 1'b0));
		go(32'h1, 3);
		`CHK("ptr addr", 8'h10, a_q[0])
		`CHK("data addr", 8'h60, a_q[1])
		`CHK("dest addr", 8'h90, a_q[2])
		`CHK("indirect kinds", 3'b001, {w_q[0], w_q[1], w_q[2]})
		`CHK("indirect data", 32'h5A5A_1234, mem.mem[8'h90])
		// 32-bit direct on a 16-bit two-clock port: split halves, doubled clocks
		mem.mem[8'h40] = 32'h0000_1357;
		mem.mem[8'h42] = 32'h0000_2468;
		setup(0, 8'h40, 8'h80, 32'h1, ctl(AM_DUAL, 1'b0, 1'b0)
			| (32'h1 << CT_NAR) | (32'h1 << CT_SLOW));
		h = hi_n;
		go(32'h1, 2);
		`CHK("split clocks", 8, hi_n - h)
		`CHK("split high", 32'h0000_1357, mem.mem[8'h80])
		`CHK("split low", 32'h0000_2468, mem.mem[8'h82])
		// priority: fresh reset, round robin first, then the fixed orders
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			int p;
			p = (i + 3) % 4;
			for (int n = 0; n < 4; n++)
				setup(n, 8'h40 + 8'(4 * n), 8'h80 + 8'(4 * n), 32'h2,
					ctl(AM_DUAL, 1'b0, 1'b0));
			go(32'h1 | (32'(p) << 1), 16);
			for (int u = 0; u < 8; u++) begin
				logic [1:0] ch;
				ch = (p == 3) ? 2'(u % 4) : ord[p][u / 2];
				`CHK("grant order", 8'h40 + 8'(4 * ch), a_q[2 * u])
			end
		end
		// single address on ch0: level request gives two units, edge one
		for (int ds = 0; ds < 2; ds++) begin
			setup(0, 8'h40, 8'h00, 32'h2,
				ctl(ds ? AM_SGL_WR : AM_SGL_RD, 1'b1, 1'(ds)));
			ext_req_n <= 4'hE;
			go(32'h1, ds ? 1 : 2);
			`CHK("single addr", ds ? 8'h00 : 8'h40, a_q[0])
			`CHK("single kind", 1'(ds), w_q[0])
			`CHK("single ack", 4'h1, k_q[0])
			ext_req_n <= 4'hF;
		end
		// abort flag blocks a fresh start
		nmi <= 1'b1;
		repeat (4) @(posedge clk);
		nmi <= 1'b0;
		repeat (4) @(posedge clk);
		rd(OFF_OP, d, rs);
		`CHK("abort flag", 32'h8, d)
		setup(1, 8'h44, 8'h84, 32'h1, ctl(AM_DUAL, 1'b0, 1'b0));
		go(32'h9, 0);
		final_report;
	end
endmodule
